// ===== src/nib_io_port.sv
// Four nibble-wide bidirectional ports with pull-up, segment and alarm sharing
`timescale 1ns/1ns
`include "nib_cfg.svh"

module nib_io_port #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic                      clkEn,
    input  wire logic                      padRst,
    input  wire logic                      wdtRst,
    input  wire logic                      optSingleSupply,
    input  wire logic                      optPortDInOnly,
    input  wire logic                      regWrEn,
    input  wire logic                      regRdEn,
    input  wire logic [`NIB_ADDR_W-1:0]    regAddr,
    input  wire logic [3:0]                regWrData,
    output logic      [3:0]                regRdData,
    input  wire logic [15:0]               padIn,
    output logic      [15:0]               padOut,
    output logic      [15:0]               padOe_n,
    output logic      [15:0]               pullupEn,
    input  wire logic [7:0]                analogSel,
    input  wire logic                      alarmIn,
    input  wire logic [7:0]                segIn,
    output logic                           alarmPinSelect,
    output logic                           heavyLoad,
    output logic                           displayOff,
    output logic                           portIrqLevel,
    output logic                           portWake
);

    nib_pkg::nib_port_s st;
    nib_pkg::nib_port_s next_st;
    logic [15:0]        pinSync;

    initial
    begin
        if (NUM_PORTS != 4)
        begin
            $error("nib_io_port: NUM_PORTS must be 4");
        end
    end

    // Register address decode
    function automatic nib_pkg::nib_reg_e decode(input logic [`NIB_ADDR_W-1:0] addr);
        nib_pkg::nib_reg_e sel;
        case (addr)
            `NIB_OFS_PORT_A: sel = nib_pkg::NIB_REG_DATA_A;
            `NIB_OFS_PORT_B: sel = nib_pkg::NIB_REG_DATA_B;
            `NIB_OFS_PORT_C: sel = nib_pkg::NIB_REG_DATA_C;
            `NIB_OFS_PORT_D: sel = nib_pkg::NIB_REG_DATA_D;
            `NIB_OFS_MISC:   sel = nib_pkg::NIB_REG_MISC;
            `NIB_OFS_PUSEG:  sel = nib_pkg::NIB_REG_PUSEG;
            `NIB_OFS_DIR_A:  sel = nib_pkg::NIB_REG_DIR_A;
            `NIB_OFS_DIR_B:  sel = nib_pkg::NIB_REG_DIR_B;
            `NIB_OFS_DIR_C:  sel = nib_pkg::NIB_REG_DIR_C;
            `NIB_OFS_DIR_D:  sel = nib_pkg::NIB_REG_DIR_D;
            default:         sel = nib_pkg::NIB_REG_NONE;
        endcase
        return sel;
    endfunction : decode

    // Port read: driven bits return the latch, input bits the pin
    function automatic nib_pkg::nib_nibble_t portRead(
        input logic [3:0] data,
        input logic [3:0] dir,
        input logic [3:0] pin
    );
        return (dir & data) | (~dir & pin);
    endfunction : portRead

    nib_pad_sync #(
        .WIDTH   (16)
    ) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .padIn   (padIn),
        .padSync (pinSync)
    );

    always_comb
    begin
        logic              segC;
        logic              segD;
        logic              alarmSel;
        logic              pullAll;
        logic [15:0]       drvData;
        logic [15:0]       drvEn;
        logic [15:0]       dirFlat;
        logic [15:0]       dataFlat;
        logic [7:0]        irqSrc;
        nib_pkg::nib_reg_e sel;

        next_st  = st;
        sel      = decode(regAddr);
        segC     = st.pullSeg[`NIB_PUS_SEG3_BIT];
        segD     = st.pullSeg[`NIB_PUS_SEG4_BIT];
        alarmSel = st.misc[`NIB_MISC_ALARM_BIT];
        pullAll  = st.pullSeg[`NIB_PUS_PULL_BIT];
        dirFlat  = st.portDir;
        dataFlat = st.portData;
        drvData  = dataFlat;
        drvEn    = dirFlat;
        irqSrc   = '0;

        // Register writes
        if (regWrEn)
        begin
            case (sel)
                nib_pkg::NIB_REG_DATA_A: next_st.portData[0] = regWrData;
                nib_pkg::NIB_REG_DATA_B: next_st.portData[1] = regWrData;
                nib_pkg::NIB_REG_DATA_C: next_st.portData[2] = regWrData;
                nib_pkg::NIB_REG_DATA_D: next_st.portData[3] = regWrData;
                nib_pkg::NIB_REG_DIR_A:  next_st.portDir[0] = regWrData;
                nib_pkg::NIB_REG_DIR_B:  next_st.portDir[1] = regWrData;
                nib_pkg::NIB_REG_DIR_C:  next_st.portDir[2] = regWrData;
                nib_pkg::NIB_REG_DIR_D:  next_st.portDir[3] = regWrData;
                nib_pkg::NIB_REG_MISC:   next_st.misc = {1'b0, regWrData[2:0]};
                nib_pkg::NIB_REG_PUSEG:  next_st.pullSeg = {regWrData[3:1], 1'b0};
                default:                 next_st = next_st;
            endcase
        end

        // Register reads, unmapped answer zero
        if (regRdEn)
        begin
            case (sel)
                nib_pkg::NIB_REG_DATA_A:
                    next_st.rdData = portRead(st.portData[0], st.portDir[0], pinSync[3:0]);
                nib_pkg::NIB_REG_DATA_B:
                    next_st.rdData = portRead(st.portData[1], st.portDir[1], pinSync[7:4]);
                nib_pkg::NIB_REG_DATA_C:
                    next_st.rdData = portRead(st.portData[2], st.portDir[2], pinSync[11:8]);
                nib_pkg::NIB_REG_DATA_D:
                    next_st.rdData = portRead(st.portData[3], st.portDir[3], pinSync[15:12]);
                nib_pkg::NIB_REG_DIR_A:  next_st.rdData = st.portDir[0];
                nib_pkg::NIB_REG_DIR_B:  next_st.rdData = st.portDir[1];
                nib_pkg::NIB_REG_DIR_C:  next_st.rdData = st.portDir[2];
                nib_pkg::NIB_REG_DIR_D:  next_st.rdData = st.portDir[3];
                nib_pkg::NIB_REG_MISC:   next_st.rdData = st.misc;
                nib_pkg::NIB_REG_PUSEG:  next_st.rdData = st.pullSeg;
                default:                 next_st.rdData = 4'h0;
            endcase
        end

        if (alarmSel)
        begin
            drvData[2:1] = {2{alarmIn}};
            drvEn[2:1]   = 2'b11;
        end

        if (segC)
        begin
            drvData[11:8] = segIn[3:0];
            drvEn[11:8]   = 4'hF;
        end

        if (segD)
        begin
            drvData[15:12] = segIn[7:4];
            drvEn[15:12]   = 4'hF;
        end

        if (optPortDInOnly)
        begin
            drvEn[15:14] = 2'b00;
        end

        next_st.padOut  = drvData;
        next_st.padOe_n = ~drvEn;

        next_st.pullupEn = {16{pullAll}} & dataFlat;
        if (optSingleSupply)
        begin
            next_st.pullupEn = next_st.pullupEn & ~drvEn;
        end

        irqSrc[3:0] = ~st.portDir[1] & ~analogSel[3:0] & ~pinSync[7:4];
        if (!segC)
        begin
            irqSrc[7:4] = ~st.portDir[2] & ~analogSel[7:4] & ~pinSync[11:8];
        end
        next_st.portIrqLevel = |irqSrc;

        // pad reset keeps or sets display off
        if (padRst)
        begin
            next_st.portData     = {4{`NIB_RST_DATA}};
            next_st.portDir      = {4{`NIB_RST_DIR}};
            next_st.pullSeg      = `NIB_RST_PUSEG;
            next_st.misc         = `NIB_RST_MISC;
            next_st.portIrqLevel = 1'b0;
            if (optSingleSupply)
            begin
                next_st.misc[`NIB_MISC_DOFF_BIT] = st.misc[`NIB_MISC_DOFF_BIT];
            end
        end

        if (wdtRst)
        begin
            next_st.portData     = {4{`NIB_RST_DATA}};
            next_st.portDir      = {4{`NIB_RST_DIR}};
            next_st.pullSeg      = `NIB_RST_PUSEG;
            next_st.misc         = `NIB_RST_MISC;
            next_st.portIrqLevel = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st          <= '0;
            st.misc     <= `NIB_RST_MISC;
            st.padOe_n  <= 16'hFFFF;
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign regRdData      = st.rdData;
    assign padOut         = st.padOut;
    assign padOe_n        = st.padOe_n;
    assign pullupEn       = st.pullupEn;
    assign alarmPinSelect = st.misc[`NIB_MISC_ALARM_BIT];
    assign heavyLoad      = st.misc[`NIB_MISC_HEAVY_BIT];
    assign displayOff     = st.misc[`NIB_MISC_DOFF_BIT];
    assign portIrqLevel   = st.portIrqLevel;
    assign portWake       = st.portIrqLevel;

endmodule : nib_io_port

// ===== src/nib_cfg.svh
// Offsets, field positions and reset values for the nibble I/O port block
`ifndef NIB_CFG_SVH
`define NIB_CFG_SVH

`define NIB_ADDR_W          5
`define NIB_OFS_PORT_A      5'h08
`define NIB_OFS_PORT_B      5'h09
`define NIB_OFS_PORT_C      5'h0A
`define NIB_OFS_PORT_D      5'h0B
`define NIB_OFS_MISC        5'h13
`define NIB_OFS_PUSEG       5'h15
`define NIB_OFS_DIR_A       5'h1B
`define NIB_OFS_DIR_B       5'h1C
`define NIB_OFS_DIR_C       5'h1D
`define NIB_OFS_DIR_D       5'h1E

`define NIB_MISC_ALARM_BIT  0
`define NIB_MISC_HEAVY_BIT  1
`define NIB_MISC_DOFF_BIT   2
`define NIB_PUS_SEG3_BIT    1
`define NIB_PUS_SEG4_BIT    2
`define NIB_PUS_PULL_BIT    3

`define NIB_RST_DATA        4'h0
`define NIB_RST_DIR         4'h0
`define NIB_RST_MISC        4'h4
`define NIB_RST_PUSEG       4'h0

`define NIB_SYS_CLK_DIV     4

`endif

// ===== src/nib_pkg.sv
// Types shared by the nibble I/O port block
package nib_pkg;

    typedef logic [3:0] nib_nibble_t;

    typedef enum logic [3:0] {
        NIB_REG_NONE,
        NIB_REG_DATA_A,
        NIB_REG_DATA_B,
        NIB_REG_DATA_C,
        NIB_REG_DATA_D,
        NIB_REG_MISC,
        NIB_REG_PUSEG,
        NIB_REG_DIR_A,
        NIB_REG_DIR_B,
        NIB_REG_DIR_C,
        NIB_REG_DIR_D
    } nib_reg_e;

    typedef struct packed {
        logic [3:0][3:0] portData;
        logic [3:0][3:0] portDir;
        logic [3:0]      misc;
        logic [3:0]      pullSeg;
        logic [3:0]      rdData;
        logic [15:0]     padOut;
        logic [15:0]     padOe_n;
        logic [15:0]     pullupEn;
        logic            portIrqLevel;
    } nib_port_s;

    typedef struct packed {
        logic [15:0] stage1;
        logic [15:0] stage2;
        logic [15:0] stage3;
        logic [15:0] stable;
    } nib_sync_s;

endpackage : nib_pkg

// ===== src/nib_pad_sync.sv
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/1ns
`include "nib_cfg.svh"

module nib_pad_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    input  wire logic [WIDTH-1:0]  padIn,
    output logic      [WIDTH-1:0]  padSync
);

    nib_pkg::nib_sync_s st;
    nib_pkg::nib_sync_s next_st;

    initial
    begin
        if (WIDTH != 16)
        begin
            $error("nib_pad_sync: WIDTH must be 16");
        end
    end

    always_comb
    begin
        next_st        = st;
        next_st.stage1 = padIn;
        next_st.stage2 = st.stage1;
        next_st.stage3 = st.stage2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st.stage2[i] == st.stage3[i])
            begin
                next_st.stable[i] = st.stage3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Idle-high start avoids a false low-level request
            st <= '1;
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign padSync = st.stable;

endmodule : nib_pad_sync

// ===== verif/nib_io_port_properties.sv
// Pin-level checks for the nibble I/O port block
`timescale 1ns/1ns
module nib_io_port_properties (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        clkEn,
    input wire logic        padRst,
    input wire logic        wdtRst,
    input wire logic        optSingleSupply,
    input wire logic        optPortDInOnly,
    input wire logic        regRdEn,
    input wire logic [4:0]  regAddr,
    input wire logic [3:0]  regRdData,
    input wire logic [15:0] padIn,
    input wire logic [15:0] padOut,
    input wire logic [15:0] padOe_n,
    input wire logic [15:0] pullupEn,
    input wire logic [7:0]  analogSel,
    input wire logic        alarmIn,
    input wire logic        alarmPinSelect,
    input wire logic        heavyLoad,
    input wire logic        displayOff,
    input wire logic        portIrqLevel,
    input wire logic        portWake
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_wake_mirror: assert property (portWake == portIrqLevel)
        else $error("wake differs from port request");
    a_dinonly_idle: assert property (optPortDInOnly |-> padOe_n[15:14] == 2'b11)
        else $error("input-only pins driven");
    a_single_pull: assert property (optSingleSupply && $past(optSingleSupply) |->
        (pullupEn & ~padOe_n) == 16'h0)
        else $error("pull-up on a driven pin");
    a_unmapped_zero: assert property (clkEn && regRdEn && regAddr == 5'h0C |=> regRdData == 4'h0)
        else $error("reserved address read nonzero");
    a_wdt_state: assert property (clkEn && wdtRst |=> displayOff && !heavyLoad && !alarmPinSelect
        ##1 padOe_n == 16'hFFFF)
        else $error("watchdog reset state wrong");
    a_padrst_doff: assert property (clkEn && padRst && !wdtRst |=>
        displayOff == (optSingleSupply ? $past(displayOff) : 1'b1))
        else $error("pad reset display bit wrong");
    a_alarm_route: assert property (clkEn && alarmPinSelect && !padRst && !wdtRst |=>
        padOut[2:1] == {2{$past(alarmIn)}} && padOe_n[2:1] == 2'b00)
        else $error("alarm not on port A pins");
    a_irq_cause: assert property ($rose(portIrqLevel) |->
        !(&$past(padIn[11:4], 5)) || !(&$past(padIn[11:4], 6)))
        else $error("request without low pin");
    a_irq_raise: assert property ((clkEn && padIn[7:4] == 4'h0 && padOe_n[7:4] == 4'hF
        && analogSel[3:0] == 4'h0) [*8] |-> portIrqLevel)
        else $error("low inputs gave no request");
    c_wdt: cover property (wdtRst);
    c_irq: cover property ($rose(portIrqLevel));
    c_alarm: cover property (alarmPinSelect);
    c_padrst: cover property (padRst && optSingleSupply);
endmodule : nib_io_port_properties

bind nib_io_port nib_io_port_properties u_props (.ref_clk, .arst_n, .clkEn, .padRst, .wdtRst,
    .optSingleSupply, .optPortDInOnly, .regRdEn, .regAddr, .regRdData, .padIn, .padOut,
    .padOe_n, .pullupEn, .analogSel, .alarmIn, .alarmPinSelect, .heavyLoad, .displayOff,
    .portIrqLevel, .portWake);

// ===== verif/nib_pad_model.sv
// Pad model: resolves pin levels from drivers, pull-ups and board
`timescale 1ns/1ns
module nib_pad_model (
    input wire logic        ref_clk,
    input wire logic [15:0] padOut,
    input wire logic [15:0] padOe_n,
    input wire logic [15:0] pullupEn,
    input wire logic [15:0] extEn,
    input wire logic [15:0] extVal,
    output logic     [15:0] padIn
);
    logic [15:0] flt = 16'h5A5A;
    always @(posedge ref_clk)
        flt <= ~flt;
    always_comb
        for (int i = 0; i < 16; i++)
            padIn[i] = !padOe_n[i] ? padOut[i] : extEn[i] ? extVal[i] : pullupEn[i] ? 1'b1 : flt[i];
endmodule : nib_pad_model

// ===== verif/nib_io_port_tb_top.sv
// Self-checking bench for the nibble I/O port block
`timescale 1ns/1ns
`define TCHK(act, exp) begin checked++; if ((act) !== (exp)) begin badCount++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, act, exp); end end
module nib_io_port_tb_top;
    logic        ref_clk, arst_n, padRst, wdtRst, optSingleSupply, optPortDInOnly;
    logic        regWrEn, regRdEn, alarmIn, alarmPinSelect, heavyLoad, displayOff;
    logic        portIrqLevel, portWake, rdPend, clkEn;
    logic [4:0]  regAddr;
    logic [3:0]  regWrData, regRdData, d, e;
    logic [7:0]  analogSel, segIn;
    logic [15:0] padIn, padOut, padOe_n, pullupEn, extEn, extVal;
    logic [3:0]  expQ[$];
    int          badCount, checked, n;
    logic [4:0]  adr [11] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h13, 5'h15, 5'h1B, 5'h1C, 5'h1D,
                             5'h1E, 5'h0C};
    logic [3:0]  msk [11] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h7, 4'hE, 4'hF, 4'hF, 4'hF, 4'hF, 4'h0};

    nib_io_port uut (.ref_clk, .arst_n, .clkEn, .padRst, .wdtRst, .optSingleSupply,
        .optPortDInOnly, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .padIn, .padOut,
        .padOe_n, .pullupEn, .analogSel, .alarmIn, .segIn, .alarmPinSelect, .heavyLoad,
        .displayOff, .portIrqLevel, .portWake);
    nib_pad_model u_pads (.ref_clk, .padOut, .padOe_n, .pullupEn, .extEn, .extVal, .padIn);

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (rdPend)
        begin
            e = expQ.pop_front();
            `TCHK(regRdData, e)
        end
        rdPend <= regRdEn;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [4:0] a, input logic [3:0] v);
        regAddr   <= a;
        regWrData <= v;
        regWrEn   <= 1'b1;
        @(posedge ref_clk);
        regWrEn   <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [3:0] v);
        regAddr <= a;
        regRdEn <= 1'b1;
        expQ.push_back(v);
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task automatic pulse(input bit w);
        if (w)
            wdtRst <= 1'b1;
        else
            padRst <= 1'b1;
        @(posedge ref_clk);
        wdtRst <= 1'b0;
        padRst <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    initial
    begin
        {arst_n, padRst, wdtRst, optSingleSupply, optPortDInOnly, regWrEn, regRdEn} = '0;
        {alarmIn, rdPend, regAddr, regWrData, analogSel, segIn} = '0;
        extEn  = 16'hFFFF;
        extVal = 16'hFFFF;
        clkEn  = 1'b1;
        void'($urandom(32'hBE5D));
        cyc(16);
        arst_n <= 1'b1;
        cyc(1);
        begin : tests
        // Input data bits read the pin, pulled high by the board
        for (int i = 0; i < 11; i++)
            rd(adr[i], (i < 4) ? 4'hF : (i == 4) ? 4'h4 : 4'h0);
        $display("test reset values done");
        for (int i = 0; i < 11; i++)
        begin
            d = 4'($urandom);
            wr(adr[i], d);
            rd(adr[i], (i < 4) ? 4'hF : d & msk[i]);
        end
        pulse(1'b1);
        rd(5'h13, 4'h4);
        $display("test register access done");
        d = 4'($urandom);
        wr(5'h1B, 4'hF);
        wr(5'h08, d);
        cyc(3);
        `TCHK(padOe_n[3:0], 4'h0)
        `TCHK(padOut[3:0], d)
        rd(5'h08, d);
        // Frozen clock enable ignores the write
        clkEn <= 1'b0;
        wr(5'h08, ~d);
        cyc(3);
        `TCHK(padOut[3:0], d)
        clkEn <= 1'b1;
        wr(5'h15, 4'h8);
        wr(5'h09, 4'hF);
        cyc(3);
        `TCHK(pullupEn[7:4], 4'hF)
        wr(5'h09, 4'h5);
        cyc(3);
        `TCHK(pullupEn[7:4], 4'h5)
        optSingleSupply <= 1'b1;
        wr(5'h08, 4'hF);
        cyc(3);
        `TCHK(pullupEn[3:0], 4'h0)
        wr(5'h15, 4'h0);
        cyc(3);
        `TCHK(pullupEn[7:4], 4'h0)
        $display("test direction and pull-up done");
        wr(5'h13, 4'h0);
        pulse(1'b0);
        rd(5'h13, 4'h0);
        optSingleSupply <= 1'b0;
        pulse(1'b0);
        rd(5'h13, 4'h4);
        $display("test pad reset done");
        wr(5'h13, 4'h1);
        alarmIn <= 1'b1;
        cyc(3);
        `TCHK({padOut[2:1], padOe_n[2:1]}, 4'hC)
        alarmIn <= 1'b0;
        cyc(2);
        `TCHK(padOut[2:1], 2'b00)
        $display("test alarm done");
        segIn <= 8'($urandom);
        wr(5'h15, 4'h2);
        wr(5'h0A, ~segIn[3:0]);
        cyc(3);
        `TCHK(padOut[11:8], segIn[3:0])
        optPortDInOnly <= 1'b1;
        wr(5'h15, 4'h4);
        cyc(3);
        `TCHK({padOut[13:12], padOe_n[15:12]}, {segIn[5:4], 4'hC})
        $display("test segment done");
        extVal[11:8] <= 4'h0;
        wr(5'h15, 4'h2);
        cyc(10);
        `TCHK(portIrqLevel, 1'b0)
        wr(5'h15, 4'h0);
        n = 0;
        while (portIrqLevel !== 1'b1 && n < 12)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (portIrqLevel !== 1'b1)
        begin
            badCount++;
            disable tests;
        end
        `TCHK({portIrqLevel, portWake}, 2'b11)
        analogSel <= 8'hF0;
        cyc(8);
        `TCHK(portIrqLevel, 1'b0)
        extVal <= 16'hFF0F;
        analogSel <= 8'h00;
        cyc(10);
        `TCHK(portIrqLevel, 1'b1)
        wr(5'h1C, 4'hF);
        wr(5'h09, 4'h0);
        cyc(10);
        `TCHK(portIrqLevel, 1'b0)
        $display("test port request done");
        end : tests
        final_report();
    end
endmodule : nib_io_port_tb_top
